/* File: common/speed_ramp_pkg.sv */
// Constants, register map and state encoding for the speed ramp profile block.
package speed_ramp_pkg;

    // Register count and indices into the register array.
    localparam int NUM_REGS = 14;
    localparam int R_ACCEL        = 0;
    localparam int R_DECEL        = 1;
    localparam int R_START_FREQ   = 2;
    localparam int R_START_HOLD   = 3;
    localparam int R_STOP_FREQ    = 4;
    localparam int R_CARRIER      = 5;
    localparam int R_STOP_HOLD    = 6;
    localparam int R_PATTERN      = 7;
    localparam int R_STOP_MODE    = 8;
    localparam int R_SC_ACC_START = 9;
    localparam int R_SC_ACC_ARR   = 10;
    localparam int R_SC_DEC_START = 11;
    localparam int R_SC_DEC_ARR   = 12;
    localparam int R_BRAKE        = 13;

    // Holding register addresses, in index order.
    localparam logic [15:0] REG_ADDR [NUM_REGS] = '{
        16'h0007, 16'h0008, 16'h0012, 16'h0013, 16'h0014, 16'h0015, 16'h0017,
        16'h0304, 16'h0306, 16'h0308, 16'h0309, 16'h030A, 16'h030B, 16'h030D};

    // Values after reset, in index order.
    localparam logic [15:0] REG_RST [NUM_REGS] = '{
        16'h01F4, 16'h01F4, 16'h000A, 16'h0000, 16'h0002, 16'h0004, 16'h0000,
        16'h0000, 16'h0000, 16'h000A, 16'h000A, 16'h000A, 16'h000A, 16'h0000};

    // Ramp pattern codes.
    localparam logic [1:0] PAT_LINEAR = 2'h0;
    localparam logic [1:0] PAT_PRESET = 2'h1;
    localparam logic [1:0] PAT_USER   = 2'h2;

    // Preset S-curve zone width in percent of maximum frequency.
    localparam logic [7:0] PRESET_PCT = 8'h05;
    localparam logic [6:0] PCT_FULL   = 7'h64;

    // Carrier frequency limits in kHz.
    localparam logic [15:0] CARRIER_MIN = 16'h0002;
    localparam logic [15:0] CARRIER_MAX = 16'h000A;

    // Control tick: one ramp step and one hold count per 10 ms.
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_MS       = 10;
    localparam int TICK_CYCLES   = (TICK_MS * 1000000) / CLK_PERIOD_NS;

    // Step divider iteration count.
    localparam logic [5:0] DIV_LAST = 6'h20;

    // Sequencer states.
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SHOLD = 2'b01,
        ST_RUN   = 2'b10,
        ST_PHOLD = 2'b11
    } state_t;

endpackage

/* File: rtl/speed_ramp_profile.sv */
// Output frequency profile generator with holding registers and start/stop sequencing.
`timescale 1ns/1ps

module speed_ramp_profile #(
    parameter int TICK_CYCLES = speed_ramp_pkg::TICK_CYCLES
) (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        nrst,
    // Holding register access.
    input  wire logic [15:0] reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_we,
    output logic      [15:0] reg_rdata,
    // Drive commands.
    input  wire logic        run_cmd,
    input  wire logic [15:0] ref_freq,
    input  wire logic [15:0] max_freq,
    input  wire logic [15:0] decel_time_alt,
    input  wire logic        decel_alt_sel,
    input  wire logic        ramp_hold,
    // Power stage outputs.
    output logic      [15:0] out_freq,
    output logic             out_enable,
    output logic             brake_force,
    output logic      [3:0]  carrier_khz,
    output logic             accel_active,
    output logic             decel_active
);

    // Reset release synchroniser.
    // Assertion acts at once; release is clocked.
    logic rst_meta_q;
    logic rst_n;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    // Run command pin synchroniser.
    // The pin is asynchronous to clk.
    logic run_meta_q;
    logic run_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_meta_q <= 1'b0;
            run_q      <= 1'b0;
        end else begin
            run_meta_q <= run_cmd;
            run_q      <= run_meta_q;
        end
    end

    // Holding registers, one per mapped address.
    // Values are stored unchecked.
    logic [15:0] regs_q [speed_ramp_pkg::NUM_REGS];
    logic [speed_ramp_pkg::NUM_REGS-1:0] hit;
    genvar gi;

    generate
        for (gi = 0; gi < speed_ramp_pkg::NUM_REGS; gi++) begin : g_reg
            assign hit[gi] = (reg_addr == speed_ramp_pkg::REG_ADDR[gi]);
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    regs_q[gi] <= speed_ramp_pkg::REG_RST[gi];
                end else if (reg_we && hit[gi]) begin
                    regs_q[gi] <= reg_wdata;
                end
            end
        end
    endgenerate

    // Read data mux; an unmapped address reads zero.
    // Data lags the address by one clock.
    logic [15:0] rd_d;
    logic [15:0] rd_q;

    always_comb begin
        rd_d = 16'h0000;
        for (int i = 0; i < speed_ramp_pkg::NUM_REGS; i++) begin
            if (hit[i]) begin
                rd_d = regs_q[i];
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_q <= 16'h0000;
        end else begin
            rd_q <= rd_d;
        end
    end
    assign reg_rdata = rd_q;

    // Named views of the settings.
    // The alternate decel time wins when selected.
    wire [15:0] accel_t    = regs_q[speed_ramp_pkg::R_ACCEL];
    wire [15:0] decel_reg  = regs_q[speed_ramp_pkg::R_DECEL];
    wire [15:0] start_f    = regs_q[speed_ramp_pkg::R_START_FREQ];
    wire [15:0] stop_f     = regs_q[speed_ramp_pkg::R_STOP_FREQ];
    wire [1:0]  pattern    = regs_q[speed_ramp_pkg::R_PATTERN][1:0];
    wire        coast_mode = regs_q[speed_ramp_pkg::R_STOP_MODE][0];
    wire [15:0] decel_t    = decel_alt_sel ? decel_time_alt : decel_reg;

    // Control tick generator.
    // Free running; not aligned to starts.
    logic [31:0] tick_cnt_q;
    wire         tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_q <= 32'h0000_0000;
        end else begin
            tick_cnt_q <= tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
        end
    end

    // Step divider: alternately computes max_freq * 65536 / time for accel and decel.
    // A zero time is taken as one.
    logic [5:0]  div_cnt_q;
    logic        div_sel_q;
    logic [16:0] rem_q;
    logic [31:0] quo_q;
    logic [31:0] step_acc_q;
    logic [31:0] step_dec_q;
    wire  [15:0] div_raw = div_sel_q ? decel_t : accel_t;
    wire  [16:0] div_den = {1'b0, (div_raw == 16'h0000) ? 16'h0001 : div_raw};
    wire  [16:0] rem_sh  = {rem_q[15:0], quo_q[31]};
    wire         rem_ge  = (rem_sh >= div_den);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_q  <= 6'h00;
            div_sel_q  <= 1'b0;
            rem_q      <= 17'h0_0000;
            quo_q      <= 32'h0000_0000;
            step_acc_q <= 32'h0000_0000;
            step_dec_q <= 32'h0000_0000;
        end else if (div_cnt_q == 6'h00) begin
            // Load a new dividend.
            rem_q     <= 17'h0_0000;
            quo_q     <= {max_freq, 16'h0000};
            div_cnt_q <= 6'h01;
        end else begin
            rem_q     <= rem_ge ? rem_sh - div_den : rem_sh;
            quo_q     <= {quo_q[30:0], rem_ge};
            div_cnt_q <= (div_cnt_q == speed_ramp_pkg::DIV_LAST) ? 6'h00 : div_cnt_q + 6'h01;
            // Last bit: store and swap sides.
            if (div_cnt_q == speed_ramp_pkg::DIV_LAST) begin
                div_sel_q <= ~div_sel_q;
                if (div_sel_q) begin
                    step_dec_q <= {quo_q[30:0], rem_ge};
                end else begin
                    step_acc_q <= {quo_q[30:0], rem_ge};
                end
            end
        end
    end

    // Sequencer and ramp registers.
    // The accumulator is 16.16 fixed point.
    speed_ramp_pkg::state_t state_q;
    logic [31:0] acc_q;
    logic [15:0] origin_q;
    logic [15:0] hold_q;
    wire  [15:0] freq = acc_q[31:16];


    // Ramp target: reference while running, zero once the run command drops.
    // The reference is on clk already.
    wire [15:0] target   = run_q ? ref_freq : 16'h0000;
    wire        going_up = (target > freq);
    wire        at_tgt   = (target == freq);

    // S-curve zone widths in percent; preset or user values per direction.
    // Only a setting's low byte is used.
    wire        preset = (pattern == speed_ramp_pkg::PAT_PRESET);
    wire [7:0]  pct_s  = preset ? speed_ramp_pkg::PRESET_PCT :
                         going_up ? regs_q[speed_ramp_pkg::R_SC_ACC_START][7:0] :
                                    regs_q[speed_ramp_pkg::R_SC_DEC_START][7:0];
    wire [7:0]  pct_e  = preset ? speed_ramp_pkg::PRESET_PCT :
                         going_up ? regs_q[speed_ramp_pkg::R_SC_ACC_ARR][7:0] :
                                    regs_q[speed_ramp_pkg::R_SC_DEC_ARR][7:0];

    // Distances from the ramp origin and to the target, scaled for comparison.
    wire [15:0] d_s     = going_up ? freq - origin_q : origin_q - freq;
    wire [15:0] d_e     = going_up ? target - freq : freq - target;
    wire [23:0] d_s_pct = d_s * speed_ramp_pkg::PCT_FULL;
    wire [23:0] d_e_pct = d_e * speed_ramp_pkg::PCT_FULL;
    wire [23:0] zone_s  = pct_s * max_freq;
    wire [23:0] zone_e  = pct_e * max_freq;
    wire        scurve  = (pattern == speed_ramp_pkg::PAT_PRESET) ||
                          (pattern == speed_ramp_pkg::PAT_USER);
    // A distance equal to the end zone is inside it; one equal to the start zone is not.
    wire        in_zone = scurve && ((d_s_pct < zone_s) || (d_e_pct <= zone_e));

    // Step size: half slope inside rounded zones, full slope on the linear part.
    // Half slope doubles the time in a zone.
    wire [31:0] step_base = going_up ? step_acc_q : step_dec_q;
    wire [31:0] step      = in_zone ? {1'b0, step_base[31:1]} : step_base;

    // Next accumulator value, clamped at the target.
    // A stop ramp ends at the stop frequency.
    wire [15:0] clamp_f  = (!going_up && (target < stop_f)) ? stop_f : target;
    wire [32:0] acc_tgt  = {1'b0, clamp_f, 16'h0000};
    wire [32:0] acc_up   = {1'b0, acc_q} + {1'b0, step};
    wire [32:0] acc_dn   = {1'b0, acc_q} - {1'b0, step};
    wire        dn_under = ({1'b0, step} > {1'b0, acc_q});
    wire [31:0] acc_next = going_up ? ((acc_up >= acc_tgt) ? acc_tgt[31:0] : acc_up[31:0]) :
                           (dn_under || (acc_dn <= acc_tgt)) ? acc_tgt[31:0] : acc_dn[31:0];

    // Stop detection and start permission.
    // A reference at or below stop waits.
    wire reach_stop = !going_up && (target <= stop_f) && (freq <= stop_f);
    wire may_start  = run_q && (ref_freq > stop_f);
    wire coast_now  = !run_q && coast_mode;
    wire ramp_step  = tick && !ramp_hold && !at_tgt;

    // State machine next-state and register updates.
    speed_ramp_pkg::state_t state_d;
    logic [31:0] acc_d;
    logic [15:0] origin_d;
    logic [15:0] hold_d;

    always_comb begin
        state_d  = state_q;
        acc_d    = acc_q;
        origin_d = origin_q;
        hold_d   = hold_q;
        case (state_q)
            speed_ramp_pkg::ST_IDLE: begin
                acc_d = 32'h0000_0000;
                if (may_start) begin
                    state_d = speed_ramp_pkg::ST_SHOLD;
                    acc_d   = {start_f, 16'h0000};
                    hold_d  = regs_q[speed_ramp_pkg::R_START_HOLD];
                end
            end
            // Hold at the starting frequency.
            speed_ramp_pkg::ST_SHOLD: begin
                if (coast_now) begin
                    state_d = speed_ramp_pkg::ST_IDLE;
                    acc_d   = 32'h0000_0000;
                end else if (tick) begin
                    if (hold_q == 16'h0000) begin
                        state_d  = speed_ramp_pkg::ST_RUN;
                        origin_d = freq;
                    end else begin
                        hold_d = hold_q - 16'h0001;
                    end
                end
            end
            // Coasting wins over any ramp step.
            speed_ramp_pkg::ST_RUN: begin
                if (coast_now) begin
                    state_d = speed_ramp_pkg::ST_IDLE;
                    acc_d   = 32'h0000_0000;
                end else if (reach_stop) begin
                    state_d = speed_ramp_pkg::ST_PHOLD;
                    acc_d   = {stop_f, 16'h0000};
                    hold_d  = regs_q[speed_ramp_pkg::R_STOP_HOLD];
                end else if (at_tgt) begin
                    origin_d = freq;
                end else if (ramp_step) begin
                    acc_d = acc_next;
                end
            end
            // Stop hold always runs to its end.
            speed_ramp_pkg::ST_PHOLD: begin
                if (tick) begin
                    if (hold_q == 16'h0000) begin
                        state_d = speed_ramp_pkg::ST_IDLE;
                        acc_d   = 32'h0000_0000;
                    end else begin
                        hold_d = hold_q - 16'h0001;
                    end
                end
            end
            // Unused codes go to idle.
            default: begin
                state_d = speed_ramp_pkg::ST_IDLE;
                acc_d   = 32'h0000_0000;
            end
        endcase
    end

    // Sequencer registers.
    // Reset leaves the drive idle at zero.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q  <= speed_ramp_pkg::ST_IDLE;
            acc_q    <= 32'h0000_0000;
            origin_q <= 16'h0000;
            hold_q   <= 16'h0000;
        end else begin
            state_q  <= state_d;
            acc_q    <= acc_d;
            origin_q <= origin_d;
            hold_q   <= hold_d;
        end
    end

    // Registered outputs to the power stage.
    wire        active_d = (state_d != speed_ramp_pkg::ST_IDLE);
    wire        dec_d    = (state_d == speed_ramp_pkg::ST_RUN) && (acc_d[31:16] > target);
    wire        acc_up_d = (state_d == speed_ramp_pkg::ST_RUN) && (acc_d[31:16] < target);
    // Carrier values outside the limits go to the nearest limit.
    wire [15:0] car_raw  = regs_q[speed_ramp_pkg::R_CARRIER];
    wire [15:0] car_lim  = (car_raw < speed_ramp_pkg::CARRIER_MIN) ? speed_ramp_pkg::CARRIER_MIN :
                           (car_raw > speed_ramp_pkg::CARRIER_MAX) ? speed_ramp_pkg::CARRIER_MAX :
                           car_raw;
    logic [15:0] out_freq_q;
    logic        out_enable_q;
    logic        brake_q;
    logic [3:0]  carrier_q;
    logic        acc_act_q;
    logic        dec_act_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_freq_q   <= 16'h0000;
            out_enable_q <= 1'b0;
            brake_q      <= 1'b0;
            carrier_q    <= speed_ramp_pkg::REG_RST[speed_ramp_pkg::R_CARRIER][3:0];
            acc_act_q    <= 1'b0;
            dec_act_q    <= 1'b0;
        end else begin
            out_freq_q   <= acc_d[31:16];
            out_enable_q <= active_d;
            brake_q      <= dec_d && regs_q[speed_ramp_pkg::R_BRAKE][0];
            carrier_q    <= car_lim[3:0];
            acc_act_q    <= acc_up_d;
            dec_act_q    <= dec_d;
        end
    end
    // Pins follow their registers.
    assign out_freq     = out_freq_q;
    assign out_enable   = out_enable_q;
    assign brake_force  = brake_q;
    assign carrier_khz  = carrier_q;
    assign accel_active = acc_act_q;
    assign decel_active = dec_act_q;

endmodule

/* File: sim/speed_ramp_properties.sv */
// Checker of output relations for the speed ramp profile block.
`timescale 1ns/1ps
module speed_ramp_properties #(
    parameter int TICK_CYCLES = 10
) (
    // Clock and reset.
    input wire logic        clk,
    input wire logic        nrst,
    // Register port.
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_we,
    input wire logic [15:0] reg_rdata,
    // Drive commands.
    input wire logic        run_cmd,
    input wire logic [15:0] ref_freq,
    input wire logic [15:0] max_freq,
    input wire logic [15:0] decel_time_alt,
    input wire logic        decel_alt_sel,
    input wire logic        ramp_hold,
    // Power stage outputs.
    input wire logic [15:0] out_freq,
    input wire logic        out_enable,
    input wire logic        brake_force,
    input wire logic [3:0]  carrier_khz,
    input wire logic        accel_active,
    input wire logic        decel_active
);
    logic [15:0] start_q;
    logic [15:0] stop_q;
    logic [15:0] mode_q;

    // Shadow copies of the settings that the relations below depend on.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            start_q <= 16'h000A;
            stop_q  <= 16'h0002;
            mode_q  <= 16'h0000;
        end else if (reg_we) begin
            if (reg_addr == 16'h0012) start_q <= reg_wdata;
            if (reg_addr == 16'h0014) stop_q <= reg_wdata;
            if (reg_addr == 16'h0306) mode_q <= reg_wdata;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_carrier_range;
        carrier_khz >= 4'h2 && carrier_khz <= 4'hA;
    endproperty
    a_carrier_range: assert property (p_carrier_range)
        else $error("carrier setting outside its range");
    property p_brake_decel;
        brake_force |-> decel_active && out_enable;
    endproperty
    a_brake_decel: assert property (p_brake_decel)
        else $error("brake active outside deceleration");
    property p_off_zero;
        !out_enable |-> out_freq == 16'h0000;
    endproperty
    a_off_zero: assert property (p_off_zero)
        else $error("frequency present while output is off");
    property p_accel_rise;
        accel_active && $past(accel_active) |-> out_freq >= $past(out_freq);
    endproperty
    a_accel_rise: assert property (p_accel_rise)
        else $error("frequency fell during acceleration");
    property p_decel_fall;
        decel_active && $past(decel_active) |-> out_freq <= $past(out_freq);
    endproperty
    a_decel_fall: assert property (p_decel_fall)
        else $error("frequency rose during deceleration");
    property p_hold_freeze;
        accel_active && $past(accel_active) && $past(ramp_hold) |-> $stable(out_freq);
    endproperty
    a_hold_freeze: assert property (p_hold_freeze)
        else $error("ramp moved while suspended");
    property p_start_at;
        $rose(out_enable) |-> out_freq == start_q;
    endproperty
    a_start_at: assert property (p_start_at)
        else $error("output did not begin at starting frequency");
    property p_start_gate;
        $rose(out_enable) |-> $past(ref_freq) > $past(stop_q);
    endproperty
    a_start_gate: assert property (p_start_gate)
        else $error("output began with reference not above stop frequency");
    property p_stop_at;
        $fell(out_enable) && mode_q[0] == 1'b0 |-> $past(out_freq) == stop_q;
    endproperty
    a_stop_at: assert property (p_stop_at)
        else $error("output ended away from stop frequency");
    property p_coast;
        $fell(run_cmd) && mode_q[0] && out_freq > stop_q |-> ##[1:4] !out_enable;
    endproperty
    a_coast: assert property (p_coast)
        else $error("output not released after run removal");
endmodule

bind speed_ramp_profile speed_ramp_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_rdata(reg_rdata), .run_cmd(run_cmd), .ref_freq(ref_freq), .max_freq(max_freq),
    .decel_time_alt(decel_time_alt), .decel_alt_sel(decel_alt_sel), .ramp_hold(ramp_hold),
    .out_freq(out_freq), .out_enable(out_enable), .brake_force(brake_force),
    .carrier_khz(carrier_khz), .accel_active(accel_active), .decel_active(decel_active));

/* File: sim/power_stage_model.sv */
// Behavioural power stage and motor that follow the frequency command.
`timescale 1ns/1ps
module power_stage_model (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        nrst,
    // Commands from the profile generator.
    input  wire logic [15:0] out_freq,
    input  wire logic        out_enable,
    input  wire logic        brake_force,
    input  wire logic [3:0]  carrier_khz,
    // Modelled shaft speed in 0.1 Hz units.
    output logic      [15:0] motor_speed
);
    logic [15:0] speed_d;

    // A driven motor locks to the command; a released one coasts down on its losses.
    assign speed_d = out_enable ? out_freq
                   : motor_speed - (motor_speed >> 4) - {15'h0000, brake_force};

    // Shaft speed state; the carrier only sets switching noise, so it is not modelled.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) motor_speed <= 16'h0000;
        else motor_speed <= speed_d;
    end
endmodule

/* File: sim/tb.sv */
// Self-checking bench for the speed ramp profile with a power stage model.
`timescale 1ns/1ps
module tb;
    localparam int T = 40;
    logic        clk = 1'b0, nrst = 1'b0, reg_we = 1'b0, run_cmd = 1'b0;
    logic        decel_alt_sel = 1'b0, ramp_hold = 1'b0;
    logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, ref_freq = 16'h0000;
    logic [15:0] max_freq = 16'h03E8, decel_time_alt = 16'h0005;
    logic [15:0] reg_rdata, out_freq, motor_speed, rd;
    logic        out_enable, brake_force, accel_active, decel_active;
    logic [3:0]  carrier_khz;
    int          bad_count = 0, num_checks = 0, cyc, n, n_lin, n_s;

    // Clock of 100 ns period.
    always #50 clk = ~clk;

    speed_ramp_profile #(.TICK_CYCLES(T)) u_dut (.clk(clk), .nrst(nrst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_rdata(reg_rdata),
        .run_cmd(run_cmd), .ref_freq(ref_freq), .max_freq(max_freq),
        .decel_time_alt(decel_time_alt), .decel_alt_sel(decel_alt_sel),
        .ramp_hold(ramp_hold), .out_freq(out_freq), .out_enable(out_enable),
        .brake_force(brake_force), .carrier_khz(carrier_khz),
        .accel_active(accel_active), .decel_active(decel_active));
    power_stage_model u_stage (.clk(clk), .nrst(nrst), .out_freq(out_freq),
        .out_enable(out_enable), .brake_force(brake_force), .carrier_khz(carrier_khz),
        .motor_speed(motor_speed));

    // Compares a seen value with the expected one and counts the outcome.
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    // Moves to just after the k-th rising edge from now.
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wreg(input logic [15:0] a, input logic [15:0] d);
        step(1);
        reg_addr = a;
        reg_wdata = d;
        reg_we = 1'b1;
        step(1);
        reg_we = 1'b0;
    endtask
    task automatic rreg(input logic [15:0] a);
        step(1);
        reg_addr = a;
        step(1);
        rd = reg_rdata;
    endtask
    // Bounded waits on the enable level and on the frequency matching or leaving a value.
    task automatic wait_en(input logic lvl);
        cyc = 0;
        while (out_enable !== lvl && cyc < 3000) begin
            step(1);
            cyc++;
        end
        chk({15'h0000, out_enable}, {15'h0000, lvl}, "enable wait");
    endtask
    task automatic wait_f(input logic [15:0] v, input logic eq);
        cyc = 0;
        while ((out_freq === v) !== eq && cyc < 3000) begin
            step(1);
            cyc++;
        end
        chk({15'h0000, out_freq === v}, {15'h0000, eq}, "frequency wait");
    endtask

    // Reset values, an unmapped place and carrier clamping.
    task automatic t_regs;
        logic [15:0] cw [3] = '{16'h0007, 16'h000F, 16'h0001};
        logic [15:0] ce [3] = '{16'h0007, 16'h000A, 16'h0002};
        for (int i = 0; i < speed_ramp_pkg::NUM_REGS; i++) begin
            rreg(speed_ramp_pkg::REG_ADDR[i]);
            chk(rd, speed_ramp_pkg::REG_RST[i], "reset value");
        end
        wreg(16'h0016, 16'h1234);
        rreg(16'h0016);
        chk(rd, 16'h0000, "unmapped read");
        for (int i = 0; i < 3; i++) begin
            wreg(16'h0015, cw[i]);
            rreg(16'h0015);
            chk(rd, cw[i], "carrier readback");
            chk({12'h000, carrier_khz}, ce[i], "carrier output");
        end
        wreg(16'h0015, 16'h0004);
    endtask

    // Starting frequency below stop frequency: no output until the reference exceeds it.
    task automatic t_gate;
        wreg(16'h0012, 16'h0005);
        wreg(16'h0014, 16'h0032);
        ref_freq = 16'h0028;
        run_cmd = 1'b1;
        step(300);
        chk({15'h0000, out_enable}, 16'h0000, "gated below stop");
        ref_freq = 16'h0032;
        step(100);
        chk({15'h0000, out_enable}, 16'h0000, "gated at stop");
        ref_freq = 16'h0064;
        wait_en(1'b1);
        chk(out_freq, 16'h0005, "first output");
        run_cmd = 1'b0;
        wait_en(1'b0);
    endtask

    // Ramp length for every pattern code, each run ended by coasting.
    task automatic t_patterns;
        for (int p = 0; p < 4; p++) begin
            wreg(16'h0304, p[15:0]);
            step(100);
            ref_freq = 16'h0258;
            run_cmd = 1'b1;
            wait_en(1'b1);
            chk(out_freq, 16'h0064, "start frequency");
            wait_f(16'h0064, 1'b0);
            wait_f(16'h0258, 1'b1);
            n = (cyc + T / 2) / T + 1;
            if (p == 0 || p == 3) chk(n[15:0], 16'h0005, "linear ticks");
            if (p == 0) n_lin = n;
            if (p == 1) chk({15'h0000, n > n_lin}, 16'h0001, "preset longer");
            if (p == 1) n_s = n;
            if (p == 2) chk({15'h0000, n > n_s}, 16'h0001, "user zones longer");
            run_cmd = 1'b0;
            step(4);
            chk({15'h0000, out_enable}, 16'h0000, "coast off");
            step(20);
            chk({15'h0000, motor_speed < 16'h0258}, 16'h0001, "motor coasting");
        end
    endtask

    // Start hold, suspended ramp, lowered reference, then a ramped stop with hold.
    task automatic t_stop;
        wreg(16'h0304, 16'h0000);
        wreg(16'h030D, 16'h0001);
        wreg(16'h0017, 16'h0001);
        wreg(16'h0013, 16'h0002);
        step(100);
        ref_freq = 16'h0258;
        run_cmd = 1'b1;
        wait_en(1'b1);
        wait_f(16'h0064, 1'b0);
        chk({15'h0000, cyc > 3 * T && cyc <= 4 * T}, 16'h0001, "start hold");
        ramp_hold = 1'b1;
        rd = out_freq;
        step(3 * T);
        chk(out_freq, rd, "ramp suspended");
        ramp_hold = 1'b0;
        wait_f(16'h0258, 1'b1);
        ref_freq = 16'h012C;
        step(2 * T);
        chk({14'h0000, decel_active, out_enable}, 16'h0003, "lowered reference");
        chk({15'h0000, brake_force}, 16'h0001, "brake in decel");
        wait_f(16'h012C, 1'b1);
        step(T);
        chk({15'h0000, brake_force}, 16'h0000, "brake after decel");
        wreg(16'h0306, 16'h0000);
        decel_alt_sel = 1'b1;
        step(100);
        run_cmd = 1'b0;
        wait_f(16'h0014, 1'b1);
        chk({15'h0000, out_enable}, 16'h0001, "held at stop");
        wait_en(1'b0);
        chk({15'h0000, cyc > T && cyc <= 2 * T + 2}, 16'h0001, "stop hold");
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Main sequence: reset, then the scenarios in turn.
    initial begin
        step(4);
        nrst = 1'b1;
        step(4);
        t_regs();
        t_gate();
        wreg(16'h0007, 16'h000A);
        wreg(16'h0008, 16'h000A);
        wreg(16'h0012, 16'h0064);
        wreg(16'h0014, 16'h0014);
        wreg(16'h0306, 16'h0001);
        t_patterns();
        t_stop();
        conclude();
    end

    // Watchdog well beyond the expected run length.
    initial begin
        #2000000;
        bad_count++;
        conclude();
    end
endmodule
